// ==== src/sbs_pkg.sv ====
package sbs_pkg;
  localparam int ADDR_W      = 16;
  localparam int BYTE_W      = 8;
  localparam int DATA_W      = 16;
  localparam int WORD_W      = 18;
  localparam int DEPTH       = 65536;
  localparam int BURST_W     = 2;
  localparam int LO_PAR_BIT  = 8;
  localparam int HI_LSB      = 9;
  localparam int HI_PAR_BIT  = 17;
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam logic [1:0] CNT_LAST  = 2'h3;
  localparam logic [1:0] CNT_STEP  = 2'h1;

  typedef enum logic [1:0] {
    SBS_IDLE  = 2'b00,
    SBS_READ  = 2'b01,
    SBS_WRITE = 2'b11
  } sbs_op_t;
endpackage

// ==== src/sbs_burst_seq.sv ====
`timescale 1ns/1ps
module sbs_burst_seq
  import sbs_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Control
  input  wire logic                  load,
  input  wire logic                  advance,
  input  wire logic [BURST_W-1:0]    start_low,
  // Result
  output logic      [BURST_W-1:0]    low_addr
);
  typedef struct packed {
    logic [BURST_W-1:0] base;
    logic [BURST_W-1:0] cnt;
  } sbs_seq_t;

  sbs_seq_t s_q;
  sbs_seq_t s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.base = start_low;
      s_d.cnt  = CNT_RESET;
    end else if (advance) begin
      s_d.cnt = s_q.cnt + CNT_STEP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Interleaved order, address used in this cycle
  assign low_addr = s_d.base ^ s_d.cnt;
endmodule // sbs_burst_seq

// ==== src/sbs_array.sv ====
`timescale 1ns/1ps
module sbs_array
  import sbs_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int WW = WORD_W
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_lo,
  input  wire logic          wr_hi,
  input  wire logic [AW-1:0] addr,
  input  wire logic [WW-1:0] wdata,
  // Read port
  output logic      [WW-1:0] rdata
);
  logic [WW-1:0] mem [0:(1<<AW)-1];

  // Self-timed write from captured controls
  always_ff @(posedge clk) begin
    if (wr_lo) begin
      mem[addr][LO_PAR_BIT:0] <= wdata[LO_PAR_BIT:0];
    end
    if (wr_hi) begin
      mem[addr][HI_PAR_BIT:HI_LSB] <= wdata[HI_PAR_BIT:HI_LSB];
    end
  end

  assign rdata = mem[addr];
endmodule // sbs_array

// ==== src/sbs_port.sv ====
`timescale 1ns/1ps
// Operation
// - 64K words of 18 bits
// - Two-bit burst counter drives low address
// - All synchronous inputs registered each edge
// - Output enable gates drivers three edges later
// - Either strobe loads address and select
// - Processor strobe loads address, starts read
// - Controller strobe selects, reads or writes
// - Advance low steps, high waits
// - Burst cycles use counter low bits
// - Interleaved order by XOR of count
// - Write enable low writes, high reads
// - Each enable gates its byte and parity
// - Pins float while any write enable low
// - Writes self-timed from registered inputs
// - Respond only when selected at load
// - One parity bit stored per byte
// - Burst data in 3-1-1-1 pattern
// - Processor strobe read, write on wait
// - Outputs float from power-up
module sbs_port
  import sbs_pkg::*;
(
  // Clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RST_B,
  // Address and strobes
  input  wire logic [sbs_pkg::ADDR_W-1:0]  WORD_ADDR,
  input  wire logic                        CHIP_SEL_N,
  input  wire logic                        PROC_ADDR_STROBE_N,
  input  wire logic                        CTRL_ADDR_STROBE_N,
  input  wire logic                        BURST_ADVANCE_N,
  // Byte writes
  input  wire logic                        LOW_BYTE_WRITE_N,
  input  wire logic                        HIGH_BYTE_WRITE_N,
  // Output enable
  input  wire logic                        OUT_EN_N,
  // Data pins
  input  wire logic [sbs_pkg::DATA_W-1:0]  DATA_IO_I,
  output logic      [sbs_pkg::DATA_W-1:0]  DATA_IO_O,
  output logic                             DATA_IO_OE_N,
  input  wire logic                        LOW_PARITY_IO_I,
  output logic                             LOW_PARITY_IO_O,
  output logic                             LOW_PARITY_IO_OE_N,
  input  wire logic                        HIGH_PARITY_IO_I,
  output logic                             HIGH_PARITY_IO_O,
  output logic                             HIGH_PARITY_IO_OE_N
);
  typedef struct packed {
    logic [1:0]          rst_sync;
    logic [ADDR_W-1:0]   addr;
    logic [WORD_W-1:0]   wdata;
    logic                sel_n;
    logic                padsp_n;
    logic                padsc_n;
    logic                adv_n;
    logic                wel_n;
    logic                weh_n;
    logic [1:0]          oe_sync;
  } sbs_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   base;
    logic                active;
    logic                wr_ok;
    logic                drive;
    logic [WORD_W-1:0]   qdata;
  } sbs_st_t;

  sbs_in_t i_q;
  sbs_in_t i_d;
  sbs_st_t s_q;
  sbs_st_t s_d;

  logic                rst_int_n;
  logic                strobe;
  logic                load;
  logic                advance;
  logic [BURST_W-1:0]  low_addr;
  logic [ADDR_W-1:0]   cur_addr;
  logic [WORD_W-1:0]   rdata;
  logic                wr_lo;
  logic                wr_hi;
  logic                any_wr;

  assign rst_int_n = i_q.rst_sync[1];

  // Capture of every synchronous input
  always_comb begin
    i_d          = i_q;
    i_d.rst_sync = {i_q.rst_sync[0], 1'b1};
    i_d.addr     = WORD_ADDR;
    i_d.wdata    = {HIGH_PARITY_IO_I, DATA_IO_I[DATA_W-1:BYTE_W],
                    LOW_PARITY_IO_I, DATA_IO_I[BYTE_W-1:0]};
    i_d.sel_n    = CHIP_SEL_N;
    i_d.padsp_n  = PROC_ADDR_STROBE_N;
    i_d.padsc_n  = CTRL_ADDR_STROBE_N;
    i_d.adv_n    = BURST_ADVANCE_N;
    i_d.wel_n    = LOW_BYTE_WRITE_N;
    i_d.weh_n    = HIGH_BYTE_WRITE_N;
    i_d.oe_sync  = {i_q.oe_sync[0], ~OUT_EN_N};
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      // Internal reset chain starts asserted, enable chain inactive
      i_q          <= '1;
      i_q.rst_sync <= 2'h0;
      i_q.oe_sync  <= 2'h0;
    end else begin
      i_q <= i_d;
    end
  end

  // Access decode on registered controls
  assign strobe  = !i_q.padsp_n || !i_q.padsc_n;
  assign load    = strobe;
  assign advance = !strobe && s_q.active && !i_q.adv_n;
  assign any_wr  = !i_q.wel_n || !i_q.weh_n;

  // Processor strobe never writes at its own edge
  assign wr_lo = s_d.active && !i_q.wel_n && !(!i_q.padsp_n && !i_q.sel_n);
  assign wr_hi = s_d.active && !i_q.weh_n && !(!i_q.padsp_n && !i_q.sel_n);

  sbs_burst_seq u_seq (
    .clk       (CLK),
    .rst_n     (rst_int_n),
    .load      (load),
    .advance   (advance),
    .start_low (i_q.addr[BURST_W-1:0]),
    .low_addr  (low_addr)
  );

  // Low bits from counter during burst and wait
  assign cur_addr = load ? i_q.addr
                         : {s_q.base[ADDR_W-1:BURST_W], low_addr};

  sbs_array u_mem (
    .clk   (CLK),
    .wr_lo (wr_lo),
    .wr_hi (wr_hi),
    .addr  (cur_addr),
    .wdata (i_q.wdata),
    .rdata (rdata)
  );

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.base   = i_q.addr;
      s_d.active = !i_q.sel_n;
    end
    // Read data valid one edge after access edge
    s_d.qdata = rdata;
    s_d.drive = s_d.active && !any_wr;
  end

  always_ff @(posedge CLK or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Pin drivers, all from flip-flops
  typedef struct packed {
    logic [WORD_W-1:0] dout;
    logic              oe_n;
  } sbs_out_t;

  sbs_out_t o_q;
  sbs_out_t o_d;

  always_comb begin
    o_d      = o_q;
    o_d.dout = s_q.qdata;
    // Enable reaches pins without waiting on an access edge
    o_d.oe_n = !(i_q.oe_sync[1] && s_d.drive);
  end

  always_ff @(posedge CLK or negedge rst_int_n) begin
    if (!rst_int_n) begin
      o_q <= '1;
    end else begin
      o_q <= o_d;
    end
  end

  assign DATA_IO_O           = {o_q.dout[HI_PAR_BIT-1:HI_LSB], o_q.dout[BYTE_W-1:0]};
  assign DATA_IO_OE_N        = o_q.oe_n;
  assign LOW_PARITY_IO_O     = o_q.dout[LO_PAR_BIT];
  assign LOW_PARITY_IO_OE_N  = o_q.oe_n;
  assign HIGH_PARITY_IO_O    = o_q.dout[HI_PAR_BIT];
  assign HIGH_PARITY_IO_OE_N = o_q.oe_n;
endmodule // sbs_port

// ==== tb/sbs_bus.sv ====
`timescale 1ns/1ps
module sbs_bus (
  // Wire parties
  input  wire logic        clk,
  input  wire logic        dut_oe_n,
  input  wire logic [17:0] dut_o,
  input  wire logic        hst_en,
  input  wire logic [17:0] hst_d,
  // Resolved level
  output logic      [17:0] w
);
  logic [17:0] last_q = 18'h0;
  always_ff @(posedge clk) last_q <= w;
  // Host drives only on writes; a floating wire shows the inverse of its last level
  always_comb w = !dut_oe_n ? dut_o : hst_en ? hst_d : ~last_q;
endmodule // sbs_bus

// ==== tb/sbs_port_chk.sv ====
`timescale 1ns/1ps
module sbs_port_chk (
  // Watched ports
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        CHIP_SEL_N,
  input wire logic        PROC_ADDR_STROBE_N,
  input wire logic        CTRL_ADDR_STROBE_N,
  input wire logic        BURST_ADVANCE_N,
  input wire logic        LOW_BYTE_WRITE_N,
  input wire logic        HIGH_BYTE_WRITE_N,
  input wire logic        OUT_EN_N,
  input wire logic [15:0] DATA_IO_O,
  input wire logic        DATA_IO_OE_N,
  input wire logic        LOW_PARITY_IO_OE_N,
  input wire logic        HIGH_PARITY_IO_OE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire w_any = !LOW_BYTE_WRITE_N || !HIGH_BYTE_WRITE_N;
  lo_oe_pair_a: assert property (LOW_PARITY_IO_OE_N == DATA_IO_OE_N)
    else $error("low parity enable split");
  hi_oe_pair_a: assert property (HIGH_PARITY_IO_OE_N == DATA_IO_OE_N)
    else $error("high parity enable split");
  wr_float_a: assert property (w_any |-> ##[1:3] DATA_IO_OE_N)
    else $error("driving during write");
  oe_off_a: assert property (OUT_EN_N [*4] |-> DATA_IO_OE_N)
    else $error("driving with output enable off");
  rst_float_a: assert property ($rose(RST_B) |-> DATA_IO_OE_N ##1 DATA_IO_OE_N)
    else $error("driving out of reset");
  desel_float_a: assert property (((!PROC_ADDR_STROBE_N || !CTRL_ADDR_STROBE_N)
    && CHIP_SEL_N) |-> ##2 DATA_IO_OE_N)
    else $error("driving when deselected");
  read_drive_a: assert property (((!OUT_EN_N) [*4] ##0
    (!PROC_ADDR_STROBE_N && !CHIP_SEL_N && !w_any))
    ##1 (!w_any && !OUT_EN_N) [*2] |-> !DATA_IO_OE_N)
    else $error("read not driven");
  wait_hold_a: assert property ((PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N
    && BURST_ADVANCE_N && !w_any) [*5] ##0 !DATA_IO_OE_N |-> $stable(DATA_IO_O))
    else $error("data moved in wait");
  cover property (!PROC_ADDR_STROBE_N && !CHIP_SEL_N);
  cover property (!CTRL_ADDR_STROBE_N && !LOW_BYTE_WRITE_N && HIGH_BYTE_WRITE_N);
  cover property (!CTRL_ADDR_STROBE_N && CHIP_SEL_N);
  cover property (!PROC_ADDR_STROBE_N ##1 (!LOW_BYTE_WRITE_N && BURST_ADVANCE_N));
endmodule // sbs_port_chk
bind sbs_port sbs_port_chk u_chk (.*);

// ==== tb/sbs_port_tb.sv ====
`timescale 1ns/1ps
module sbs_port_tb;
  import sbs_pkg::*;
  logic        clk = 0, rst_b = 0, cs_n = 0, ps_n = 1, cs_s_n = 1, adv_n = 1;
  logic        lw_n = 1, hw_n = 1, oe_n = 1, hen = 0, oe_d, lpo, lpoe, hpo, hpoe;
  logic [15:0] addr = 16'h0, dout, b;
  logic [17:0] hd = 18'h0, w, o;
  logic [17:0] mem [int];
  logic [31:0] lf = 32'h3222;
  int          mismatches = 0, n_tests = 0;
  always #50 clk = ~clk;
  assign o = {hpo, dout[15:8], lpo, dout[7:0]};
  sbs_port DUT (.CLK(clk), .RST_B(rst_b), .WORD_ADDR(addr), .CHIP_SEL_N(cs_n),
    .PROC_ADDR_STROBE_N(ps_n), .CTRL_ADDR_STROBE_N(cs_s_n), .BURST_ADVANCE_N(adv_n),
    .LOW_BYTE_WRITE_N(lw_n), .HIGH_BYTE_WRITE_N(hw_n), .OUT_EN_N(oe_n),
    .DATA_IO_I({w[16:9], w[7:0]}), .DATA_IO_O(dout), .DATA_IO_OE_N(oe_d),
    .LOW_PARITY_IO_I(w[8]), .LOW_PARITY_IO_O(lpo), .LOW_PARITY_IO_OE_N(lpoe),
    .HIGH_PARITY_IO_I(w[17]), .HIGH_PARITY_IO_O(hpo), .HIGH_PARITY_IO_OE_N(hpoe));
  sbs_bus u_bus (.clk(clk), .dut_oe_n(oe_d), .dut_o(o), .hst_en(hen), .hst_d(hd), .w(w));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Back-to-back controller writes; strobe stays low between calls
  task automatic wr(input logic [15:0] a, input logic l, input logic h);
    @(negedge clk);
    lf = lfsr(lf);
    {cs_s_n, addr, lw_n, hw_n, hen, hd} = {1'b0, a, l, h, 1'b1, lf[17:0]};
    if (!l) mem[a][8:0] = lf[8:0];
    if (!h) mem[a][17:9] = lf[17:9];
  endtask
  // Strobe, four advances (last wraps), then waits; pins show junk after the strobe
  task automatic burst(input logic [15:0] a, input logic p);
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      if (k > 2) cmp(o, mem[{a[15:2], a[1:0] ^ ((k < 7) ? 2'(k - 3) : 2'h0)}]);
      if (k > 2) cmp({17'h0, oe_d}, 18'h0);
      {ps_n, cs_s_n, adv_n} = {!(k == 0 && p), !(k == 0 && !p), !(k > 0 && k < 5)};
      addr = (k == 0) ? a : ~a;
    end
  endtask
  initial begin
    #3000000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1;
    repeat (4) @(negedge clk);
    for (int g = 0; g < 3; g++) begin
      lf = lfsr(lf);
      b = {lf[15:2], 2'h0};
      for (int i = 0; i < 4; i++) wr(b | 16'(i), 1'b0, 1'b0);
      wr(b | 16'h1, 1'b0, 1'b1);
      wr(b | 16'h2, 1'b1, 1'b0);
      @(negedge clk);
      lf = lfsr(lf);
      {cs_s_n, ps_n, addr, lw_n, hw_n, hen, hd} = {2'h2, b | 16'h3, 3'h6, lf[17:0]};
      @(negedge clk);
      {ps_n, lw_n, hen} = 3'h5;
      mem[b | 16'h3][8:0] = lf[8:0];
      @(negedge clk);
      {ps_n, lw_n, hw_n, hen, oe_n} = 5'h1c;
      repeat (3) @(negedge clk);
      burst(b | 16'(g), 1'b1);
      burst(b | 16'(g + 1), 1'b0);
      @(negedge clk);
      {cs_n, cs_s_n} = 2'h2;
      @(negedge clk);
      {cs_n, cs_s_n} = 2'h1;
      repeat (2) @(negedge clk);
      cmp({17'h0, oe_d}, 18'h1);
      oe_n = 1;
      repeat (4) @(negedge clk);
      $display("group %0d done", g);
    end
    finish_test();
  end
endmodule // sbs_port_tb
